// [verilog/fhr_host_port.sv]
`timescale 1ns/1ps
`default_nettype none
module fhr_host_port (
   input wire logic ref_clk,
   input wire logic rst,
   input wire fhr_pkg::fhr_pins_t pins_in,
   output logic [11:0] ac_out,
   output logic skip,
   output logic done_flag,
   output logic error_flag,
   output logic transfer_request_flag,
   output fhr_pkg::fhr_media_req_t media_req,
   output logic media_start,
   input wire fhr_pkg::fhr_media_rsp_t media_rsp
);
   import fhr_pkg::*;

   localparam int PIN_W = $bits(fhr_pins_t);

   typedef enum logic [8:0] {
      S_IDLE = 9'h001,
      S_CMDHI = 9'h002,
      S_DISP = 9'h004,
      S_FILL = 9'h008,
      S_EMPTY = 9'h010,
      S_SECT = 9'h020,
      S_TRACK = 9'h040,
      S_MEDIA = 9'h080,
      S_FIN = 9'h100
   } fhr_state_t;

   // words per buffer transfer, by mode, word length and density
   function automatic logic [8:0] word_total(input logic m2, input logic b8, input logic dd);
      logic big;
      big = m2 & dd;
      if (b8) begin
         word_total = big ? CNT_DD_B8 : CNT_SD_B8;
      end else begin
         word_total = big ? CNT_DD_B12 : CNT_SD_B12;
      end
   endfunction

   // status image; unused positions stay zero
   function automatic logic [11:0] status_word(input logic m2, input logic [7:0] f);
      status_word = '0;
      status_word[ST_RDY_POS] = f[ST_RDY_POS];
      status_word[ST_DD_POS] = f[ST_DD_POS];
      status_word[ST_ID_POS] = f[ST_ID_POS];
      status_word[ST_PAR_POS] = f[ST_PAR_POS];
      status_word[ST_CRC_POS] = f[ST_CRC_POS];
      if (m2) begin
         status_word[ST_DEN_POS] = f[ST_DEN_POS];
         status_word[ST_DENERR_POS] = f[ST_DENERR_POS];
         status_word[ST_DUAL_POS] = 1'b1;
      end
   endfunction

   // two-stage synchronisers; a third stage only for strobe edges
   logic [PIN_W-1:0] s1_q;
   logic [PIN_W-1:0] s2_q;
   logic [PIN_W-1:0] s3_q;
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_sync
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= pins_in[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
            end
         end
      end
   endgenerate

   fhr_pins_t pin;
   fhr_pins_t pin_old;
   assign pin = s2_q;
   assign pin_old = s3_q;

   // rising edges of the instruction strobes
   wire logic init_p = pin.init_instruction & ~pin_old.init_instruction;
   wire logic lcd_p = pin.load_command_instruction & ~pin_old.load_command_instruction;
   wire logic xdr_p = pin.transfer_data_instruction & ~pin_old.transfer_data_instruction;
   wire logic str_p = pin.skip_on_transfer_request_instruction & ~pin_old.skip_on_transfer_request_instruction;
   wire logic ser_p = pin.skip_on_error_instruction & ~pin_old.skip_on_error_instruction;
   wire logic sdn_p = pin.skip_on_done_instruction & ~pin_old.skip_on_done_instruction;

   fhr_state_t state_q, state_d;
   logic [11:0] ir_q, ir_d;
   logic [11:0] cmd_q, cmd_d;
   logic [11:0] errcode_q, errcode_d;
   logic [7:0] flags_q, flags_d;
   logic [8:0] cnt_q, cnt_d;
   logic [6:0] track_q, track_d;
   logic [4:0] sector_q, sector_d;
   logic done_q, err_q, treq_q, errpend_q, errpend_d;
   logic [2:0] boot_q;
   logic mode2_q;
   wire logic init_req = boot_q[2];
   logic start_q, start_d;
   logic done_set, err_set, treq_set;
   logic buf_we;
   logic [11:0] buf_wdata;
   logic [11:0] buf_mem [BUF_DEPTH];

   // command field decode from the held command word
   wire fhr_fn_t fn = fhr_fn_t'(cmd_q[CMD_FN_POS +: 3]);
   wire logic b8 = cmd_q[CMD_WLEN_POS];
   wire logic drv = cmd_q[CMD_DRV_POS];
   wire logic req_dd = mode2_q & cmd_q[CMD_DEN_POS];
   wire logic act_dd = pin.media_double[drv];
   wire logic den_bad = req_dd != act_dd;
   wire logic [8:0] last_idx = word_total(mode2_q, b8, req_dd) - 9'h001;
   wire logic cnt_last = cnt_q == last_idx;
   wire logic [11:0] host_word = b8 ? {4'h0, pin.ac[BYTE_W-1:0]} : pin.ac;
   wire logic sect_ok = (pin.ac >= SECT_MIN) && (pin.ac <= SECT_MAX);
   wire logic track_ok = pin.ac <= TRACK_MAX;
   wire logic two_part = mode2_q & pin.ac[CMD_WLEN_POS];

   // host facing flags; a set in the same cycle as a skip clear wins
   assign skip = (sdn_p & done_q) | (ser_p & err_q) | (str_p & treq_q);
   assign done_flag = done_q;
   assign error_flag = err_q;
   assign transfer_request_flag = treq_q;
   assign ac_out = ir_q;
   assign media_start = start_q;
   assign media_req = '{fn: fn, drive: drv, dbl: req_dd, track: track_q, sector: sector_q};

   // function sequencer
   always_comb begin
      state_d = state_q;
      ir_d = ir_q;
      cmd_d = cmd_q;
      errcode_d = errcode_q;
      flags_d = flags_q;
      cnt_d = cnt_q;
      track_d = track_q;
      sector_d = sector_q;
      errpend_d = errpend_q;
      start_d = 1'b0;
      done_set = 1'b0;
      err_set = 1'b0;
      treq_set = 1'b0;
      buf_we = 1'b0;
      buf_wdata = host_word;
      case (state_q)
         S_IDLE: begin
            if (lcd_p) begin
               // only the low eight bits matter in mode 1 and bit 7 never
               cmd_d = {4'h0, 1'b0, pin.ac[6:0]};
               flags_d = '0;
               flags_d[ST_PAR_POS] = pin.cmd_parity_err;
               // the error code must survive until a read error register command fetches it
               if (fhr_fn_t'(pin.ac[CMD_FN_POS +: 3]) != FN_ERRREG) begin
                  errcode_d = ERR_NONE;
               end
               errpend_d = 1'b0;
               if (two_part) begin
                  treq_set = 1'b1;
                  state_d = S_CMDHI;
               end else begin
                  state_d = S_DISP;
               end
            end else if (xdr_p) begin
               ir_d = ir_q; // status stays readable after done
            end
         end
         S_CMDHI: begin
            if (xdr_p) begin
               // upper four bits carry nothing this block uses
               state_d = S_DISP;
            end
         end
         S_DISP: begin
            cnt_d = '0;
            if (flags_q[ST_PAR_POS] && !mode2_q) begin
               errcode_d = ERR_PAR;
               errpend_d = 1'b1;
               state_d = S_FIN;
            end else begin
               case (fn)
                  FN_FILL: begin
                     treq_set = 1'b1;
                     state_d = S_FILL;
                  end
                  FN_EMPTY: begin
                     ir_d = buf_mem[0];
                     treq_set = 1'b1;
                     state_d = S_EMPTY;
                  end
                  FN_WRITE, FN_READ, FN_WRDEL: begin
                     treq_set = 1'b1;
                     state_d = S_SECT;
                  end
                  FN_DENSITY: begin
                     if (mode2_q) begin
                        start_d = 1'b1;
                        state_d = S_MEDIA;
                     end else begin
                        state_d = S_FIN;
                     end
                  end
                  FN_STATUS: begin
                     flags_d[ST_RDY_POS] = pin.drive_ready[drv];
                     state_d = S_FIN;
                  end
                  FN_ERRREG: begin
                     ir_d = errcode_q; // status word is not loaded here
                     done_set = 1'b1;
                     state_d = S_IDLE;
                  end
                  default: state_d = S_FIN;
               endcase
            end
         end
         S_FILL: begin
            if (xdr_p) begin
               buf_we = 1'b1;
               cnt_d = cnt_q + 9'h001;
               if (cnt_last) begin
                  state_d = S_FIN;
               end else begin
                  treq_set = 1'b1;
               end
            end
         end
         S_EMPTY: begin
            if (xdr_p) begin
               cnt_d = cnt_q + 9'h001;
               if (cnt_last) begin
                  state_d = S_FIN;
               end else begin
                  ir_d = buf_mem[cnt_d[7:0]];
                  treq_set = 1'b1;
               end
            end
         end
         S_SECT: begin
            if (xdr_p) begin
               sector_d = pin.ac[4:0];
               if (!sect_ok) begin
                  errcode_d = ERR_SECT;
                  errpend_d = 1'b1;
                  state_d = S_FIN;
               end else begin
                  treq_set = 1'b1;
                  state_d = S_TRACK;
               end
            end
         end
         S_TRACK: begin
            if (xdr_p) begin
               track_d = pin.ac[6:0];
               if (!track_ok) begin
                  errcode_d = ERR_TRACK;
                  errpend_d = 1'b1;
                  state_d = S_FIN;
               end else if (den_bad) begin
                  flags_d[ST_DENERR_POS] = mode2_q;
                  errcode_d = ERR_DEN;
                  errpend_d = 1'b1;
                  state_d = S_FIN;
               end else begin
                  start_d = 1'b1;
                  state_d = S_MEDIA;
               end
            end
         end
         S_MEDIA: begin
            if (media_rsp.done) begin
               if (fn == FN_READ) begin
                  flags_d[ST_DD_POS] = media_rsp.deleted;
                  flags_d[ST_CRC_POS] = media_rsp.crc_err;
                  if (media_rsp.crc_err) begin
                     errcode_d = ERR_CRC;
                     errpend_d = 1'b1;
                  end
               end
               if (fn == FN_WRDEL) begin
                  flags_d[ST_DD_POS] = 1'b1;
               end
               state_d = S_FIN;
            end
         end
         S_FIN: begin
            // live density of the selected drive goes with the status in mode 2; status_word drops it in mode 1
            flags_d[ST_DEN_POS] = act_dd;
            ir_d = status_word(mode2_q, flags_d);
            done_set = 1'b1;
            err_set = errpend_q;
            state_d = S_IDLE;
         end
         default: state_d = S_IDLE;
      endcase
      // initialize overrides any function in progress
      if (init_req || init_p) begin
         flags_d = '0;
         flags_d[ST_ID_POS] = 1'b1;
         flags_d[ST_RDY_POS] = pin.drive_ready[0];
         errcode_d = ERR_NONE;
         errpend_d = 1'b0;
         start_d = 1'b0;
         treq_set = 1'b0;
         buf_we = 1'b0;
         cmd_d = '0;
         state_d = S_FIN;
      end
   end

   // sequencer registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= S_IDLE;
         ir_q <= '0;
         cmd_q <= '0;
         errcode_q <= ERR_NONE;
         flags_q <= '0;
         cnt_q <= '0;
         track_q <= '0;
         sector_q <= '0;
         errpend_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ir_q <= ir_d;
         cmd_q <= cmd_d;
         errcode_q <= errcode_d;
         flags_q <= flags_d;
         cnt_q <= cnt_d;
         track_q <= track_d;
         sector_q <= sector_d;
         errpend_q <= errpend_d;
         start_q <= start_d;
      end
   end

   // host flags: set beats the skip clear of the same cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         done_q <= 1'b0;
         err_q <= 1'b0;
         treq_q <= 1'b0;
      end else if (init_p) begin
         done_q <= 1'b0;
         err_q <= 1'b0;
         treq_q <= 1'b0;
      end else begin
         done_q <= done_set | (done_q & ~sdn_p);
         err_q <= err_set | (err_q & ~ser_p);
         treq_q <= treq_set | (treq_q & ~str_p);
      end
   end

   // power-up initialize waits until the synchronisers hold real pin values, else strap and ready read as zero
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         boot_q <= 3'h1;
         mode2_q <= 1'b0;
      end else begin
         boot_q <= {boot_q[1:0], 1'b0};
         if (init_req) begin
            mode2_q <= pin.mode2_strap;
         end
      end
   end

   // sector buffer; contents are not reset, like a real ram
   always_ff @(posedge ref_clk) begin
      if (buf_we) begin
         buf_mem[cnt_q[7:0]] <= buf_wdata;
      end
   end
endmodule
`default_nettype wire

// [verilog/fhr_pkg.sv]
package fhr_pkg;
   // vector index n carries documented bit 11-n (bit 0 is the msb)
   localparam int WORD_W = 12;
   localparam int CMD_WLEN_POS = 6;
   localparam int CMD_DEN_POS = 5;
   localparam int CMD_DRV_POS = 4;
   localparam int CMD_FN_POS = 1;
   localparam int BYTE_W = 8;
   localparam int ST_RDY_POS = 7;
   localparam int ST_DD_POS = 6;
   localparam int ST_DEN_POS = 5;
   localparam int ST_DENERR_POS = 4;
   localparam int ST_DUAL_POS = 3;
   localparam int ST_ID_POS = 2;
   localparam int ST_PAR_POS = 1;
   localparam int ST_CRC_POS = 0;
   localparam logic [11:0] TRACK_MAX = 12'h04C;
   localparam logic [11:0] SECT_MIN = 12'h001;
   localparam logic [11:0] SECT_MAX = 12'h01A;
   localparam logic [11:0] ERR_NONE = 12'h000;
   localparam logic [11:0] ERR_SECT = 12'h038;
   localparam logic [11:0] ERR_TRACK = 12'h020;
   localparam logic [11:0] ERR_CRC = 12'h080;
   localparam logic [11:0] ERR_PAR = 12'h088;
   localparam logic [11:0] ERR_DEN = 12'h0A0;
   localparam logic [8:0] CNT_SD_B8 = 9'h080;
   localparam logic [8:0] CNT_SD_B12 = 9'h040;
   localparam logic [8:0] CNT_DD_B8 = 9'h100;
   localparam logic [8:0] CNT_DD_B12 = 9'h080;
   localparam int BUF_DEPTH = 256;

   typedef enum logic [2:0] {
      FN_FILL = 3'h0,
      FN_EMPTY = 3'h1,
      FN_WRITE = 3'h2,
      FN_READ = 3'h3,
      FN_DENSITY = 3'h4,
      FN_STATUS = 3'h5,
      FN_WRDEL = 3'h6,
      FN_ERRREG = 3'h7
   } fhr_fn_t;

   // pins from the host and the drives, all asynchronous to ref_clk
   typedef struct packed {
      logic init_instruction;
      logic load_command_instruction;
      logic transfer_data_instruction;
      logic skip_on_transfer_request_instruction;
      logic skip_on_error_instruction;
      logic skip_on_done_instruction;
      logic mode2_strap;
      logic cmd_parity_err;
      logic [1:0] drive_ready;
      logic [1:0] media_double;
      logic [11:0] ac;
   } fhr_pins_t;

   typedef struct packed {
      fhr_fn_t fn;
      logic drive;
      logic dbl;
      logic [6:0] track;
      logic [4:0] sector;
   } fhr_media_req_t;

   typedef struct packed {
      logic done;
      logic crc_err;
      logic deleted;
   } fhr_media_rsp_t;
endpackage

// [tb/fhr_host_port_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module fhr_host_port_properties
   import fhr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire fhr_pkg::fhr_pins_t pins_in,
   input wire logic [11:0] ac_out,
   input wire logic skip,
   input wire logic done_flag,
   input wire logic error_flag,
   input wire logic transfer_request_flag,
   input wire fhr_pkg::fhr_media_req_t media_req,
   input wire logic media_start,
   input wire fhr_pkg::fhr_media_rsp_t media_rsp
);
   wire logic sect_go;
   // a sector access handed on to the media engine
   assign sect_go = media_start && (media_req.fn inside {FN_WRITE, FN_READ, FN_WRDEL});
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   a_track_range: assert property (sect_go |-> media_req.track <= 7'h4C)
      else $error("bad track started");
   a_sector_range: assert property (sect_go |-> media_req.sector inside {[5'h01:5'h1A]})
      else $error("bad sector started");
   a_density_match: assert property (sect_go |-> media_req.dbl == pins_in.media_double[media_req.drive])
      else $error("density mismatch started");
   a_done_follows: assert property (media_rsp.done |-> ##[1:2] done_flag)
      else $error("no done after media");
   a_crc_flagged: assert property (media_rsp.done && media_rsp.crc_err |-> ##[1:2] (error_flag && ac_out[0]))
      else $error("crc not reported");
   a_status_unused: assert property ($rose(done_flag) |-> ac_out[11:8] == 4'h0)
      else $error("unused status bits set");
   a_error_with_done: assert property ($rose(error_flag) |-> done_flag)
      else $error("error without done");
   a_done_cleared: assert property ($fell(done_flag) |-> $past(skip))
      else $error("done dropped without skip");
   c_sector: cover property (sect_go);
   c_error: cover property ($rose(error_flag));
   c_tr_skip: cover property (skip && transfer_request_flag);
endmodule
bind fhr_host_port fhr_host_port_properties u_fhr_host_port_properties (.ref_clk, .rst, .pins_in, .ac_out,
   .skip, .done_flag, .error_flag, .transfer_request_flag, .media_req, .media_start, .media_rsp);
`default_nettype wire

// [tb/fhr_media_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fhr_media_model
   import fhr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic media_start,
   input wire fhr_pkg::fhr_media_req_t media_req,
   input wire logic crc_en,
   input wire logic del_en,
   input wire logic [7:0] lat,
   output fhr_pkg::fhr_media_rsp_t media_rsp,
   output int starts
);
   logic busy;
   logic [7:0] cnt;
   wire logic rd;
   assign rd = media_req.fn == FN_READ;
   // flags toggle while not valid, so nothing can lean on stale values
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         media_rsp <= '0;
         busy <= 1'b0;
         cnt <= 8'h00;
         starts <= 0;
      end else begin
         media_rsp <= {1'b0, ~media_rsp.crc_err, ~media_rsp.deleted};
         if (media_start) begin
            busy <= 1'b1;
            cnt <= lat;
            starts <= starts + 1;
         end else if (busy && cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end else if (busy) begin
            busy <= 1'b0;
            media_rsp <= {1'b1, crc_en && rd, del_en && rd};
         end
      end
   end
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fhr_pkg::*;
   localparam int P_LCD = 22;
   localparam int P_XDR = 21;
   localparam int P_STR = 20;
   localparam int P_SER = 19;
   localparam int P_SDN = 18;
   localparam int P_M2 = 17;
   localparam int P_PAR = 16;
   localparam logic [11:0] BAD_S [3] = '{12'h000, 12'h01B, 12'h005};
   localparam logic [11:0] BAD_T [3] = '{12'h005, 12'h005, 12'h04D};
   localparam logic [11:0] BAD_E [3] = '{ERR_SECT, ERR_SECT, ERR_TRACK};
   logic ref_clk, rst, skip, done_flag, error_flag, transfer_request_flag, media_start;
   logic crc_en, del_en, sk;
   logic [23:0] pins_v;
   logic [11:0] ac_out;
   logic [7:0] lat;
   fhr_media_req_t media_req;
   fhr_media_rsp_t media_rsp;
   int starts;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   fhr_host_port u_fhr_host_port (.ref_clk, .rst, .pins_in(fhr_pins_t'(pins_v)), .ac_out, .skip,
      .done_flag, .error_flag, .transfer_request_flag, .media_req, .media_start, .media_rsp);
   fhr_media_model u_fhr_media_model (.ref_clk, .rst, .media_start, .media_req, .crc_en, .del_en,
      .lat, .media_rsp, .starts);
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // the whole run needs about 12k cycles; a hang ends at 40k, over three times that
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         finish_test();
      end
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // strobes are held 4 clocks each way to clear the two-flop synchroniser
   task automatic strobe(input int b);
      sk = 1'b0;
      @(posedge ref_clk) pins_v[b] <= 1'b1;
      repeat (4) @(negedge ref_clk) sk |= skip;
      @(posedge ref_clk) pins_v[b] <= 1'b0;
      repeat (4) @(negedge ref_clk) sk |= skip;
   endtask
   task automatic put(input int b, input logic [11:0] v);
      @(posedge ref_clk) pins_v[11:0] <= v;
      strobe(b);
   endtask
   task automatic wait_flag(input int lim);
      for (int n = 0; n < lim && transfer_request_flag !== 1'b1 && done_flag !== 1'b1; n++) begin
         @(negedge ref_clk);
      end
   endtask
   // an early done ends the address phases, so refused parameters are simply skipped
   task automatic param(input logic [11:0] v);
      wait_flag(400);
      if (transfer_request_flag === 1'b1) begin
         strobe(P_STR);
         put(P_XDR, v);
      end
   endtask
   task automatic fin(input logic [11:0] es, input logic [11:0] m, input logic ee);
      wait_flag(3000);
      chk({11'h000, done_flag}, 12'h001);
      chk(ac_out & m, es);
      chk({11'h000, error_flag}, {11'h000, ee});
      strobe(P_SER);
      chk({11'h000, sk}, {11'h000, ee});
      strobe(P_SDN);
      chk({11'h000, sk}, 12'h001);
   endtask
   task automatic cfg(input logic c, input logic d, input logic [7:0] l);
      @(posedge ref_clk);
      crc_en <= c;
      del_en <= d;
      lat <= l;
   endtask
   task automatic reset_dut(input logic m2);
      @(posedge ref_clk);
      rst <= 1'b1;
      pins_v[P_M2] <= m2;
      pins_v[13:12] <= {m2, 1'b0};
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
   endtask
   task automatic s_mode1_misc;
      int s0;
      fin(12'h084, 12'hFFF, 1'b0);
      put(P_LCD, 12'h008);
      fin(12'h000, 12'hF7F, 1'b0);
      s0 = starts;
      @(posedge ref_clk) pins_v[P_PAR] <= 1'b1;
      put(P_LCD, 12'h006);
      @(posedge ref_clk) pins_v[P_PAR] <= 1'b0;
      fin(12'h002, 12'hF7F, 1'b1);
      chk(12'(starts - s0), 12'h000);
   endtask
   // high nibble and the ignored bit are set; drive 1 selected
   task automatic s_sector;
      logic [2:0] fc;
      for (int i = 0; i < 3; i++) begin
         fc = (i == 0) ? 3'h2 : (i == 1) ? 3'h3 : 3'h6;
         cfg(1'b0, 1'b1, 8'h28);
         put(P_LCD, {8'hF9, fc, 1'b0});
         param(12'h01A);
         param(12'h04C);
         fin({5'h00, fc != 3'h2, 6'h00}, 12'hF7F, 1'b0);
         chk({media_req.drive, media_req.fn, 1'b0, media_req.track}, {1'b1, fc, 8'h4C});
         chk({7'h00, media_req.sector}, 12'h01A);
      end
      cfg(1'b1, 1'b0, 8'h00);
      put(P_LCD, 12'h006);
      param(12'h001);
      param(12'h000);
      fin(12'h001, 12'hF7F, 1'b1);
      put(P_LCD, 12'h00E);
      fin(ERR_CRC, 12'hFFF, 1'b0);
      cfg(1'b0, 1'b0, 8'h00);
   endtask
   task automatic s_range;
      int s0;
      for (int i = 0; i < 3; i++) begin
         s0 = starts;
         put(P_LCD, 12'h006);
         param(BAD_S[i]);
         param(BAD_T[i]);
         fin(12'h000, 12'hF7F, 1'b1);
         chk(12'(starts - s0), 12'h000);
         put(P_LCD, 12'h00E);
         fin(BAD_E[i], 12'hFFF, 1'b0);
      end
   endtask
   // fill then empty; eight-bit words come back with the top nibble clear
   task automatic s_buffer(input logic [11:0] opt, input int n, input logic [11:0] st);
      logic [11:0] v;
      put(P_LCD, opt);
      for (int i = 0; i < n; i++) begin
         v = 12'(i) * 12'h0A7 + 12'h501;
         wait_flag(400);
         chk({11'h000, transfer_request_flag}, 12'h001);
         param(v);
      end
      fin(st, 12'hF7F, 1'b0);
      put(P_LCD, opt | 12'h002);
      for (int i = 0; i < n; i++) begin
         v = 12'(i) * 12'h0A7 + 12'h501;
         wait_flag(400);
         strobe(P_STR);
         chk(ac_out, opt[6] ? {4'h0, v[7:0]} : v);
         put(P_XDR, 12'h000);
      end
      fin(st, 12'hF7F, 1'b0);
   endtask
   task automatic s_mode2;
      int s0;
      fin(12'h08C, 12'hFFF, 1'b0);
      put(P_LCD, 12'h03A);
      fin(12'h0A8, 12'hFFF, 1'b0);
      s0 = starts;
      put(P_LCD, 12'h016);
      param(12'h003);
      param(12'h00A);
      fin(12'h038, 12'hF7F, 1'b1);
      chk(12'(starts - s0), 12'h000);
      // set density goes to the media engine with no address phase
      s0 = starts;
      put(P_LCD, 12'h008);
      fin(12'h008, 12'hFFF, 1'b0);
      chk(12'(starts - s0), 12'h001);
      // eight-bit command in mode 2 needs a second transfer for the upper bits
      put(P_LCD, 12'h04A);
      param(12'h000);
      fin(12'h088, 12'hFFF, 1'b0);
   endtask
   initial begin
      pins_v = 24'h00C000;
      rst = 1'b1;
      crc_en = 1'b0;
      del_en = 1'b0;
      lat = 8'h00;
      reset_dut(1'b0);
      s_mode1_misc();
      s_sector();
      s_range();
      s_buffer(12'h010, 64, 12'h000);
      s_buffer(12'h050, 128, 12'h000);
      reset_dut(1'b1);
      s_mode2();
      s_buffer(12'h020, 128, 12'h008);
      finish_test();
   end
endmodule
`default_nettype wire
